// [design/cfg_pkg.sv]
package cfg_pkg;

  // Core clock.
  localparam int CLK_PERIOD_NS = 20;

  // Busy low pulse: the longest allowed time, rounded down to whole cycles.
  localparam int BUSY_MAX_NS = 45;
  localparam int BUSY_CYC = (BUSY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : BUSY_MAX_NS / CLK_PERIOD_NS;

  // Error/status low pulse: the least time, rounded up to whole cycles.
  localparam int STATUS_MIN_US = 10;
  localparam int STATUS_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Configuration complete to user mode on the internal clock source.
  localparam int CD2UM_MIN_US = 6;
  localparam int CD2UM_CYC = (CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Configuration complete to user mode in start-up clock periods.
  localparam int USER_CLK_PERIODS = 136;

  localparam int TMR_W = 16;

  // Test-port instruction register.
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CFG_LOAD = 4'h2;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h5;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  localparam int BYTE_W = 8;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
    TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {
    LD_RESTART, LD_LOAD, LD_ERROR, LD_INIT, LD_USER
  } load_state_t;

  typedef struct packed {
    logic chip_select_n;
    logic chip_select;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [BYTE_W-1:0] data;
  } ppa_pins_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtag_pins_t;

  typedef struct packed {
    logic config_restart_n;
    logic chain_enable_in_n;
    logic user_startup_clock;
    logic use_user_clock;
  } ctl_pins_t;

endpackage

// [design/cfg_image_mem.sv]
`timescale 1ns/100ps
module cfg_image_mem #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  input logic mclk,
  input logic srst,
  input logic wr_en,
  input logic [AW-1:0] wr_addr,
  input logic [DW-1:0] wr_data,
  input logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_d;

  always_comb
  begin
    rd_d = mem[rd_addr];
  end

  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= rd_d;
    end
  end

endmodule

// [design/cfg_loader.sv]
`timescale 1ns/100ps
module cfg_loader #(
  parameter int IMAGE_BYTES = 16,
  parameter int AW = 4,
  parameter int STATUS_CYC = cfg_pkg::STATUS_CYC,
  parameter int CD2UM_CYC = cfg_pkg::CD2UM_CYC,
  parameter int USER_CLK_PERIODS = cfg_pkg::USER_CLK_PERIODS
) (
  input logic mclk,
  input logic srst,
  input cfg_pkg::ppa_pins_t ppa_pins,
  input cfg_pkg::jtag_pins_t jtag_pins,
  input cfg_pkg::ctl_pins_t ctl_pins,
  output logic ready_busy_n,
  output logic data_bit_seven_out,
  output logic data_bit_seven_oe,
  output logic tdo_out,
  output logic tdo_oe,
  output logic config_complete,
  output logic config_status_n,
  output logic chain_enable_out_n,
  output logic pins_hiz,
  output logic user_mode,
  input logic [AW-1:0] image_rd_addr,
  output logic [cfg_pkg::BYTE_W-1:0] image_rd_data
);

  localparam logic [AW-1:0] LAST_IDX = AW'(IMAGE_BYTES - 1);
  localparam logic [cfg_pkg::TMR_W-1:0] STATUS_END = cfg_pkg::TMR_W'(STATUS_CYC - 1);
  localparam logic [cfg_pkg::TMR_W-1:0] CD2UM_END = cfg_pkg::TMR_W'(CD2UM_CYC - 1);
  localparam logic [cfg_pkg::TMR_W-1:0] UCLK_END = cfg_pkg::TMR_W'(USER_CLK_PERIODS - 1);
  localparam logic [1:0] BUSY_LOAD = 2'(cfg_pkg::BUSY_CYC);

  function automatic cfg_pkg::tap_state_t tap_next(input cfg_pkg::tap_state_t s,
                                                    input logic tms);
    cfg_pkg::tap_state_t n;
    n = s;
    unique case (s)
      cfg_pkg::TAP_RESET: n = tms ? cfg_pkg::TAP_RESET : cfg_pkg::TAP_IDLE;
      cfg_pkg::TAP_IDLE: n = tms ? cfg_pkg::TAP_SEL_DR : cfg_pkg::TAP_IDLE;
      cfg_pkg::TAP_SEL_DR: n = tms ? cfg_pkg::TAP_SEL_IR : cfg_pkg::TAP_CAP_DR;
      cfg_pkg::TAP_CAP_DR: n = tms ? cfg_pkg::TAP_EX1_DR : cfg_pkg::TAP_SHIFT_DR;
      cfg_pkg::TAP_SHIFT_DR: n = tms ? cfg_pkg::TAP_EX1_DR : cfg_pkg::TAP_SHIFT_DR;
      cfg_pkg::TAP_EX1_DR: n = tms ? cfg_pkg::TAP_UPD_DR : cfg_pkg::TAP_PAUSE_DR;
      cfg_pkg::TAP_PAUSE_DR: n = tms ? cfg_pkg::TAP_EX2_DR : cfg_pkg::TAP_PAUSE_DR;
      cfg_pkg::TAP_EX2_DR: n = tms ? cfg_pkg::TAP_UPD_DR : cfg_pkg::TAP_SHIFT_DR;
      cfg_pkg::TAP_UPD_DR: n = tms ? cfg_pkg::TAP_SEL_DR : cfg_pkg::TAP_IDLE;
      cfg_pkg::TAP_SEL_IR: n = tms ? cfg_pkg::TAP_RESET : cfg_pkg::TAP_CAP_IR;
      cfg_pkg::TAP_CAP_IR: n = tms ? cfg_pkg::TAP_EX1_IR : cfg_pkg::TAP_SHIFT_IR;
      cfg_pkg::TAP_SHIFT_IR: n = tms ? cfg_pkg::TAP_EX1_IR : cfg_pkg::TAP_SHIFT_IR;
      cfg_pkg::TAP_EX1_IR: n = tms ? cfg_pkg::TAP_UPD_IR : cfg_pkg::TAP_PAUSE_IR;
      cfg_pkg::TAP_PAUSE_IR: n = tms ? cfg_pkg::TAP_EX2_IR : cfg_pkg::TAP_PAUSE_IR;
      cfg_pkg::TAP_EX2_IR: n = tms ? cfg_pkg::TAP_UPD_IR : cfg_pkg::TAP_SHIFT_IR;
      cfg_pkg::TAP_UPD_IR: n = tms ? cfg_pkg::TAP_SEL_DR : cfg_pkg::TAP_IDLE;
    endcase
    return n;
  endfunction

  // Pin synchronisers; only the second stage and later are looked at.
  cfg_pkg::ppa_pins_t ppa_s1_q, ppa_s2_q;
  cfg_pkg::jtag_pins_t jt_s1_q, jt_s2_q, jt_s3_q;
  cfg_pkg::ctl_pins_t ctl_s1_q, ctl_s2_q, ctl_s3_q;
  logic ws_s3_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ppa_s1_q <= '1;
      ppa_s2_q <= '1;
      ws_s3_q <= 1'b1;
      jt_s1_q <= '1;
      jt_s2_q <= '1;
      jt_s3_q <= '1;
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
      ctl_s3_q <= '0;
    end
    else
    begin
      ppa_s1_q <= ppa_pins;
      ppa_s2_q <= ppa_s1_q;
      ws_s3_q <= ppa_s2_q.write_strobe_n;
      jt_s1_q <= jtag_pins;
      jt_s2_q <= jt_s1_q;
      jt_s3_q <= jt_s2_q;
      ctl_s1_q <= ctl_pins;
      ctl_s2_q <= ctl_s1_q;
      ctl_s3_q <= ctl_s2_q;
    end
  end

  logic tck_rise, tck_fall, ws_rise, uclk_rise, trst_on, restart_on;
  assign tck_rise = jt_s2_q.tck & ~jt_s3_q.tck;
  assign tck_fall = ~jt_s2_q.tck & jt_s3_q.tck;
  assign ws_rise = ppa_s2_q.write_strobe_n & ~ws_s3_q;
  assign uclk_rise = ctl_s2_q.user_startup_clock & ~ctl_s3_q.user_startup_clock;
  assign trst_on = ~jt_s2_q.trst_n;
  assign restart_on = ~ctl_s2_q.config_restart_n;

  // Test-port state.
  cfg_pkg::tap_state_t tap_q, tap_d;
  logic [cfg_pkg::IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
  logic [cfg_pkg::BYTE_W-1:0] dr_q, dr_d;
  logic byp_q, byp_d, tdo_q, tdo_d, toe_q, toe_d, upd_q, upd_d;
  cfg_pkg::load_state_t ld_q, ld_d;
  logic cfg_sel, scan_ok, dr_long;

  assign cfg_sel = (ir_q == cfg_pkg::IR_CFG_LOAD);
  // Boundary scan is only honoured before loading starts or in user mode.
  assign scan_ok = (ld_q == cfg_pkg::LD_USER) || (ld_q == cfg_pkg::LD_RESTART);
  assign dr_long = cfg_sel || ((ir_q == cfg_pkg::IR_SAMPLE) && scan_ok);

  always_comb
  begin
    tap_d = tap_q;
    ir_d = ir_q;
    irs_d = irs_q;
    dr_d = dr_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    toe_d = toe_q;
    upd_d = 1'b0;
    if (tck_rise)
    begin
      case (tap_q)
        cfg_pkg::TAP_RESET: ir_d = cfg_pkg::IR_BYPASS;
        cfg_pkg::TAP_CAP_IR: irs_d = cfg_pkg::IR_CAPTURE;
        cfg_pkg::TAP_SHIFT_IR: irs_d = {jt_s2_q.tdi, irs_q[cfg_pkg::IR_W-1:1]};
        cfg_pkg::TAP_UPD_IR: ir_d = irs_q;
        cfg_pkg::TAP_CAP_DR:
        begin
          dr_d = (dr_long && !cfg_sel) ? ppa_s2_q.data : '0;
          byp_d = 1'b0;
        end
        cfg_pkg::TAP_SHIFT_DR:
        begin
          dr_d = {jt_s2_q.tdi, dr_q[cfg_pkg::BYTE_W-1:1]};
          byp_d = jt_s2_q.tdi;
        end
        cfg_pkg::TAP_UPD_DR: upd_d = cfg_sel;
        default: ;
      endcase
      tap_d = tap_next(tap_q, jt_s2_q.tms);
    end
    if (tck_fall)
    begin
      toe_d = (tap_q == cfg_pkg::TAP_SHIFT_IR) || (tap_q == cfg_pkg::TAP_SHIFT_DR);
      if (tap_q == cfg_pkg::TAP_SHIFT_IR)
      begin
        tdo_d = irs_q[0];
      end
      else
      begin
        tdo_d = dr_long ? dr_q[0] : byp_q;
      end
    end
    if (trst_on)
    begin
      tap_d = cfg_pkg::TAP_RESET;
      ir_d = cfg_pkg::IR_BYPASS;
      toe_d = 1'b0;
    end
  end

  // Only the test reset touches this group; the chip reset leaves it alone.
  always_ff @(posedge mclk)
  begin
    tap_q <= tap_d;
    ir_q <= ir_d;
    irs_q <= irs_d;
    dr_q <= dr_d;
    byp_q <= byp_d;
    tdo_q <= tdo_d;
    toe_q <= toe_d;
    upd_q <= upd_d;
  end

  // Loader state.
  logic [AW-1:0] cnt_q, cnt_d;
  logic [cfg_pkg::BYTE_W-1:0] sum_q, sum_d, byte_in, sum_new;
  logic [cfg_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic [1:0] busy_q, busy_d;
  logic rb_q, rb_d, done_q, done_d, stat_q, stat_d, ceo_q, ceo_d, user_q, user_d;
  logic hiz_q, hiz_d, d7_q, d7_d, d7oe_q, d7oe_d;
  logic cs_on, take_ppa, take_jtag, take;

  assign cs_on = ~ppa_s2_q.chip_select_n & ppa_s2_q.chip_select;
  assign take_ppa = ws_rise & cs_on & ~cfg_sel & (busy_q == 2'h0);
  assign take_jtag = upd_q & cfg_sel;
  assign take = (ld_q == cfg_pkg::LD_LOAD) & ~ctl_s2_q.chain_enable_in_n
                & (take_ppa | take_jtag);
  assign byte_in = take_jtag ? dr_q : ppa_s2_q.data;
  assign sum_new = sum_q ^ byte_in;

  always_comb
  begin
    ld_d = ld_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    tmr_d = tmr_q;
    done_d = done_q;
    stat_d = stat_q;
    ceo_d = ceo_q;
    user_d = user_q;
    busy_d = (busy_q != 2'h0) ? busy_q - 2'h1 : 2'h0;
    unique case (ld_q)
      cfg_pkg::LD_RESTART:
      begin
        cnt_d = '0;
        sum_d = '0;
        tmr_d = tmr_q + 1'b1;
        if (tmr_q == STATUS_END)
        begin
          ld_d = cfg_pkg::LD_LOAD;
          stat_d = 1'b1;
          tmr_d = '0;
        end
      end
      cfg_pkg::LD_LOAD:
      begin
        if (take)
        begin
          busy_d = BUSY_LOAD;
          cnt_d = cnt_q + 1'b1;
          sum_d = sum_new;
          if (cnt_q == LAST_IDX)
          begin
            if (sum_new == '0)
            begin
              ld_d = cfg_pkg::LD_INIT;
              done_d = 1'b1;
              ceo_d = 1'b0;
            end
            else
            begin
              ld_d = cfg_pkg::LD_ERROR;
              stat_d = 1'b0;
            end
          end
        end
      end
      cfg_pkg::LD_ERROR:
      begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q == STATUS_END)
        begin
          ld_d = cfg_pkg::LD_LOAD;
          stat_d = 1'b1;
          cnt_d = '0;
          sum_d = '0;
          tmr_d = '0;
        end
      end
      cfg_pkg::LD_INIT:
      begin
        if (ctl_s2_q.use_user_clock)
        begin
          if (uclk_rise)
          begin
            tmr_d = tmr_q + 1'b1;
            if (tmr_q == UCLK_END)
            begin
              ld_d = cfg_pkg::LD_USER;
              user_d = 1'b1;
            end
          end
        end
        else
        begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q == CD2UM_END)
          begin
            ld_d = cfg_pkg::LD_USER;
            user_d = 1'b1;
          end
        end
      end
      cfg_pkg::LD_USER: ;
    endcase
    if (restart_on)
    begin
      ld_d = cfg_pkg::LD_RESTART;
      done_d = 1'b0;
      stat_d = 1'b0;
      ceo_d = 1'b1;
      user_d = 1'b0;
      tmr_d = '0;
      busy_d = 2'h0;
    end
    rb_d = (busy_d == 2'h0);
    d7oe_d = ~ppa_s2_q.read_strobe_n & (ld_q != cfg_pkg::LD_USER) & ~cfg_sel;
    d7_d = rb_q;
    hiz_d = cfg_sel & (ld_q != cfg_pkg::LD_USER);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ld_q <= cfg_pkg::LD_RESTART;
      cnt_q <= '0;
      sum_q <= '0;
      tmr_q <= '0;
      busy_q <= 2'h0;
      rb_q <= 1'b1;
      done_q <= 1'b0;
      stat_q <= 1'b0;
      ceo_q <= 1'b1;
      user_q <= 1'b0;
      hiz_q <= 1'b0;
      d7_q <= 1'b0;
      d7oe_q <= 1'b0;
    end
    else
    begin
      ld_q <= ld_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      tmr_q <= tmr_d;
      busy_q <= busy_d;
      rb_q <= rb_d;
      done_q <= done_d;
      stat_q <= stat_d;
      ceo_q <= ceo_d;
      user_q <= user_d;
      hiz_q <= hiz_d;
      d7_q <= d7_d;
      d7oe_q <= d7oe_d;
    end
  end

  cfg_image_mem #(
    .DW(cfg_pkg::BYTE_W),
    .AW(AW)
  ) u_image (
    .mclk(mclk),
    .srst(srst),
    .wr_en(take),
    .wr_addr(cnt_q),
    .wr_data(byte_in),
    .rd_addr(image_rd_addr),
    .rd_data(image_rd_data)
  );

  assign ready_busy_n = rb_q;
  assign data_bit_seven_out = d7_q;
  assign data_bit_seven_oe = d7oe_q;
  assign tdo_out = tdo_q;
  assign tdo_oe = toe_q;
  assign config_complete = done_q;
  assign config_status_n = stat_q;
  assign chain_enable_out_n = ceo_q;
  assign pins_hiz = hiz_q;
  assign user_mode = user_q;

endmodule

// [bench/cfg_loader_asserts.sv]
`timescale 1ns/100ps
module cfg_loader_asserts #(
  parameter int STATUS_CYC = 20,
  parameter int CD2UM_CYC = 10
) (
  input logic mclk,
  input logic srst,
  input cfg_pkg::ppa_pins_t ppa_pins,
  input cfg_pkg::ctl_pins_t ctl_pins,
  input logic ready_busy_n,
  input logic data_bit_seven_out,
  input logic data_bit_seven_oe,
  input logic config_complete,
  input logic config_status_n,
  input logic chain_enable_out_n,
  input logic pins_hiz,
  input logic user_mode
);
  localparam int REL_MAX = 2000;
  logic [15:0] low_q, low_d, on_q, on_d, rel_q, rel_d;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  // Count cycles of status low, of complete high, and of status low with restart released.
  always_comb
  begin
    low_d = (srst || config_status_n) ? 16'h0000 : low_q + 16'h0001;
    on_d = (srst || !config_complete) ? 16'h0000 : on_q + 16'h0001;
    rel_d = (srst || !ctl_pins.config_restart_n || config_status_n) ? 16'h0000
            : rel_q + 16'h0001;
  end
  always_ff @(posedge mclk)
  begin
    low_q <= low_d;
    on_q <= on_d;
    rel_q <= rel_d;
  end
  busy_width_a: assert property ($fell(ready_busy_n) |=> !ready_busy_n ##1 ready_busy_n)
    else $error("busy pulse width wrong");
  status_min_a: assert property ($rose(config_status_n) |-> low_q >= STATUS_CYC)
    else $error("status low pulse too short");
  restart_clear_a: assert property ($fell(ctl_pins.config_restart_n) |->
    ##[1:40] (!config_complete && !config_status_n)) else $error("restart did not clear");
  status_release_a: assert property (rel_q <= REL_MAX)
    else $error("status not released");
  bit7_copy_a: assert property (data_bit_seven_oe && $past(data_bit_seven_oe) |->
    data_bit_seven_out == $past(ready_busy_n)) else $error("bit seven not ready state");
  bit7_drive_a: assert property ($fell(ppa_pins.read_strobe_n) && !user_mode && !pins_hiz
    |-> ##[1:4] data_bit_seven_oe) else $error("bit seven not driven");
  done_chain_a: assert property ($rose(config_complete) |-> !chain_enable_out_n)
    else $error("chain output not low at complete");
  user_delay_a: assert property ($rose(user_mode) && !ctl_pins.use_user_clock |->
    on_q >= CD2UM_CYC && on_q <= CD2UM_CYC + 2) else $error("user mode delay wrong");
  hiz_quiet_a: assert property (pins_hiz && $past(pins_hiz) |-> !data_bit_seven_oe)
    else $error("bit seven driven in test load");
  cover property ($rose(user_mode));
  cover property ($rose(pins_hiz));
  cover property ($fell(config_status_n) && ctl_pins.config_restart_n);
endmodule

bind cfg_loader cfg_loader_asserts #(.STATUS_CYC(STATUS_CYC), .CD2UM_CYC(CD2UM_CYC)) chk (
  .mclk(mclk), .srst(srst), .ppa_pins(ppa_pins), .ctl_pins(ctl_pins),
  .ready_busy_n(ready_busy_n), .data_bit_seven_out(data_bit_seven_out),
  .data_bit_seven_oe(data_bit_seven_oe), .config_complete(config_complete),
  .config_status_n(config_status_n), .chain_enable_out_n(chain_enable_out_n),
  .pins_hiz(pins_hiz), .user_mode(user_mode));

// [bench/cfg_host.sv]
`timescale 1ns/100ps
module cfg_host (
  input logic mclk,
  input logic ready_busy_n,
  input logic d7_oe,
  input logic d7_out,
  input logic tdo_oe,
  input logic tdo_out,
  output cfg_pkg::ppa_pins_t ppa_pins,
  output cfg_pkg::jtag_pins_t jtag_pins,
  output cfg_pkg::ctl_pins_t ctl_pins
);
  logic tdo_last = 1'b0;
  // Test reset starts low; chain enable stays low for the whole run.
  initial
  begin
    ppa_pins = 12'hb00;
    jtag_pins = 4'h6;
    ctl_pins = 4'h8;
    repeat (8) @(posedge mclk);
    #1 jtag_pins.trst_n = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic restart();
    ctl_pins.config_restart_n = 1'b0;
    cyc(2000);
    ctl_pins.config_restart_n = 1'b1;
    cyc(2000);
  endtask
  task automatic wr(input logic [7:0] b, output logic seen);
    seen = 1'b0;
    ppa_pins.data = b;
    ppa_pins.chip_select_n = 1'b0;
    ppa_pins.chip_select = 1'b1;
    ppa_pins.write_strobe_n = 1'b0;
    cyc(4);
    ppa_pins.write_strobe_n = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      cyc(1);
      seen |= !ready_busy_n;
      if (seen && ready_busy_n) break;
    end
    ppa_pins.data = ~b;
    cyc(1);
  endtask
  task automatic rd(output logic lvl);
    ppa_pins.data = 8'hff;
    ppa_pins.read_strobe_n = 1'b0;
    cyc(6);
    lvl = d7_oe ? d7_out : ~ppa_pins.data[7];
    ppa_pins.read_strobe_n = 1'b1;
    cyc(2);
  endtask
  // The level returned is the one valid at the rising edge of this test clock.
  task automatic tck(input logic ms, input logic di, output logic dout);
    jtag_pins.tms = ms;
    jtag_pins.tdi = di;
    cyc(4);
    jtag_pins.tck = 1'b1;
    cyc(4);
    dout = tdo_oe ? tdo_out : ~tdo_last;
    tdo_last = dout;
    jtag_pins.tck = 1'b0;
  endtask
  task automatic uclk(input int n);
    repeat (n)
    begin
      ctl_pins.user_startup_clock = 1'b1;
      cyc(4);
      ctl_pins.user_startup_clock = 1'b0;
      cyc(4);
    end
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
  localparam int NB = 4;
  localparam int ST = 20;
  localparam int CD = 10;
  localparam int UP = 4;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] rd_addr = 4'h0;
  logic rbn, d7o, d7e, tdo, tdoe, cdone, stn, ceo, hiz, umode;
  logic [7:0] rdat;
  cfg_pkg::ppa_pins_t passive_parallel_async;
  cfg_pkg::jtag_pins_t jt;
  cfg_pkg::ctl_pins_t ctl;
  int failures = 0;
  int total_checks = 0;
  always #10 mclk = ~mclk;
  cfg_host host (.mclk(mclk), .ready_busy_n(rbn), .d7_oe(d7e), .d7_out(d7o), .tdo_oe(tdoe),
    .tdo_out(tdo), .ppa_pins(passive_parallel_async), .jtag_pins(jt), .ctl_pins(ctl));
  cfg_loader #(.IMAGE_BYTES(NB), .STATUS_CYC(ST), .CD2UM_CYC(CD), .USER_CLK_PERIODS(UP)) DUT (
    .mclk(mclk), .srst(srst), .ppa_pins(passive_parallel_async), .jtag_pins(jt), .ctl_pins(ctl),
    .ready_busy_n(rbn), .data_bit_seven_out(d7o), .data_bit_seven_oe(d7e), .tdo_out(tdo),
    .tdo_oe(tdoe), .config_complete(cdone), .config_status_n(stn), .chain_enable_out_n(ceo),
    .pins_hiz(hiz), .user_mode(umode), .image_rd_addr(rd_addr), .image_rd_data(rdat));
  task automatic final_report();
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic waitv(ref logic s, input logic v, input int n);
    repeat (n) if (s !== v) host.cyc(1);
    chk_bit(s, v);
    if (s !== v) final_report();
  endtask
  task automatic scan(input logic ir, input logic [7:0] v, input int n, output logic [7:0] o);
    logic d;
    o = 8'h00;
    host.tck(1'b1, 1'b0, d);
    if (ir) host.tck(1'b1, 1'b0, d);
    host.tck(1'b0, 1'b0, d);
    host.tck(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) host.tck(i == n - 1, v[i], o[i]);
    host.tck(1'b1, 1'b0, d);
    host.tck(1'b0, 1'b0, d);
  endtask
  // The image model: the last byte closes the XOR to zero, or to one when bad.
  task automatic load(input logic bad, input logic viaj);
    logic [7:0] img[$];
    logic [7:0] x, o;
    logic seen;
    x = 8'h00;
    for (int i = 0; i < NB; i++)
    begin
      img.push_back(i < NB - 1 ? 8'($urandom) : x ^ {7'h00, bad});
      x ^= img[i];
      if (viaj) scan(1'b0, img[i], 8, o);
      else
      begin
        host.wr(img[i], seen);
        chk_bit(seen, 1'b1);
      end
    end
    if (bad)
    begin
      chk_bit(stn, 1'b0);
      waitv(stn, 1'b1, ST + 5);
    end
    else
    begin
      chk_bit(cdone, 1'b1);
      chk_bit(ceo, 1'b0);
      if (!viaj) chk_bit(umode, 1'b0);
      for (int i = 0; i < NB; i++)
      begin
        rd_addr = 4'(i);
        host.cyc(2);
        chk_byte(rdat, img[i]);
      end
    end
  endtask
  initial
  begin
    logic b;
    logic [7:0] v, o;
    v = 8'($urandom(73326));
    repeat (5) @(posedge mclk);
    #1 srst = 1'b0;
    chk_bit(rbn, 1'b1);
    chk_bit(cdone, 1'b0);
    chk_bit(stn, 1'b0);
    chk_bit(ceo, 1'b1);
    host.restart();
    chk_bit(stn, 1'b1);
    host.rd(b);
    chk_bit(b, 1'b1);
    load(1'b0, 1'b0);
    waitv(umode, 1'b1, CD + 4);
    host.wr(v, b);
    chk_bit(b, 1'b0);
    host.rd(b);
    chk_bit(b, 1'b0);
    host.restart();
    chk_bit(cdone, 1'b0);
    chk_bit(umode, 1'b0);
    load(1'b1, 1'b0);
    host.ctl_pins.use_user_clock = 1'b1;
    load(1'b0, 1'b0);
    host.uclk(UP - 1);
    chk_bit(umode, 1'b0);
    host.uclk(1);
    chk_bit(umode, 1'b1);
    host.ctl_pins.use_user_clock = 1'b0;
    host.restart();
    for (int i = 0; i < 5; i++) host.tck(1'b1, 1'b0, b);
    host.tck(1'b0, 1'b0, b);
    chk_bit(tdoe, 1'b0);
    scan(1'b0, v, 8, o);
    chk_byte({o[7:1], 1'b0}, {v[6:0], 1'b0});
    chk_bit(rbn, 1'b1);
    scan(1'b1, {4'h0, cfg_pkg::IR_SAMPLE}, 4, o);
    scan(1'b0, ~v, 8, o);
    chk_byte({o[7:1], 1'b0}, {~v[6:0], 1'b0});
    scan(1'b1, {4'h0, cfg_pkg::IR_CFG_LOAD}, 4, o);
    chk_byte(o, 8'h01);
    chk_bit(hiz, 1'b1);
    host.rd(b);
    chk_bit(b, 1'b0);
    load(1'b1, 1'b1);
    load(1'b0, 1'b1);
    waitv(umode, 1'b1, CD + 4);
    // After configuration the sample instruction captures the data pins again.
    host.ppa_pins.data = v;
    scan(1'b1, {4'h0, cfg_pkg::IR_SAMPLE}, 4, o);
    scan(1'b0, ~v, 8, o);
    chk_byte(o, v);
    final_report();
  end
endmodule
